/* tid_pkg.sv */
// shared opcodes, fields and constants of the instruction decoder
package tid_pkg;
	typedef enum logic [5:0] {
		OP_NOP, OP_OPTION, OP_SLEEP, OP_WDT_CLR, OP_DIR_LOAD, OP_MOVWF,
		OP_CLRW, OP_CLRF, OP_SUB, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_ADD,
		OP_MOVF, OP_COMF, OP_INC, OP_DEC_SKIP, OP_ROT_RIGHT, OP_ROT_LEFT,
		OP_SWAP, OP_INC_SKIP, OP_BIT_CLR, OP_BIT_SET, OP_TEST_CLR,
		OP_TEST_SET, OP_RET_LIT, OP_CALL, OP_BRANCH, OP_MOVE_LIT,
		OP_OR_LIT, OP_AND_LIT, OP_XOR_LIT, OP_ILLEGAL
	} tid_op_t;

	// instruction field positions
	localparam int REG_MSB = 4;
	localparam int REG_LSB = 0;
	localparam int DEST_POS = 5;
	localparam int BIT_MSB = 7;
	localparam int BIT_LSB = 5;
	localparam int LIT_MSB = 7;
	localparam int TGT_MSB = 8;
	localparam int DIR_SEL_MSB = 2;

	// file addresses and selectors seen by the decoder
	localparam logic [4:0] TIMER_ADDR = 5'h01;
	localparam logic [4:0] PORT_ADDR = 5'h06;
	localparam logic [2:0] DIR_PORT_SEL = 3'h6;

	// reset values
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] OPTION_RESET = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [8:0] PC_RESET = 9'h000;

	// last divider count of the instruction cycle, and program counter steps
	localparam logic [1:0] DIV_LAST = 2'h3;
	localparam logic [8:0] PC_STEP = 9'h001;
	localparam logic [8:0] PC_SKIP_STEP = 9'h002;

	// opcode patterns
	localparam logic [11:0] P_NOP = 12'b0000_0000_0000;
	localparam logic [11:0] P_OPTION = 12'b0000_0000_0010;
	localparam logic [11:0] P_SLEEP = 12'b0000_0000_0011;
	localparam logic [11:0] P_WDT = 12'b0000_0000_0100;
	localparam logic [11:0] P_DIR = 12'b0000_0000_0???;
	localparam logic [11:0] P_MOVWF = 12'b0000_001?_????;
	localparam logic [11:0] P_CLRW = 12'b0000_0100_0000;
	localparam logic [11:0] P_CLRF = 12'b0000_011?_????;
	localparam logic [11:0] P_SUB = 12'b0000_10??_????;
	localparam logic [11:0] P_DEC = 12'b0000_11??_????;
	localparam logic [11:0] P_OR = 12'b0001_00??_????;
	localparam logic [11:0] P_AND = 12'b0001_01??_????;
	localparam logic [11:0] P_XOR = 12'b0001_10??_????;
	localparam logic [11:0] P_ADD = 12'b0001_11??_????;
	localparam logic [11:0] P_MOVF = 12'b0010_00??_????;
	localparam logic [11:0] P_COMF = 12'b0010_01??_????;
	localparam logic [11:0] P_INC = 12'b0010_10??_????;
	localparam logic [11:0] P_DECSK = 12'b0010_11??_????;
	localparam logic [11:0] P_RR = 12'b0011_00??_????;
	localparam logic [11:0] P_RL = 12'b0011_01??_????;
	localparam logic [11:0] P_SWAP = 12'b0011_10??_????;
	localparam logic [11:0] P_INCSK = 12'b0011_11??_????;
	localparam logic [11:0] P_BCLR = 12'b0100_????_????;
	localparam logic [11:0] P_BSET = 12'b0101_????_????;
	localparam logic [11:0] P_TCLR = 12'b0110_????_????;
	localparam logic [11:0] P_TSET = 12'b0111_????_????;
	localparam logic [11:0] P_RETL = 12'b1000_????_????;
	localparam logic [11:0] P_CALL = 12'b1001_????_????;
	localparam logic [11:0] P_BRANCH = 12'b101?_????_????;
	localparam logic [11:0] P_MOVL = 12'b1100_????_????;
	localparam logic [11:0] P_ORL = 12'b1101_????_????;
	localparam logic [11:0] P_ANDL = 12'b1110_????_????;
	localparam logic [11:0] P_XORL = 12'b1111_????_????;

	function automatic tid_op_t tid_decode(input logic [11:0] w);
		tid_op_t op;
		op = OP_ILLEGAL;
		casez (w)
			P_NOP: op = OP_NOP;
			P_OPTION: op = OP_OPTION;
			P_SLEEP: op = OP_SLEEP;
			P_WDT: op = OP_WDT_CLR;
			P_DIR: op = OP_DIR_LOAD;
			P_MOVWF: op = OP_MOVWF;
			P_CLRW: op = OP_CLRW;
			P_CLRF: op = OP_CLRF;
			P_SUB: op = OP_SUB;
			P_DEC: op = OP_DEC;
			P_OR: op = OP_OR;
			P_AND: op = OP_AND;
			P_XOR: op = OP_XOR;
			P_ADD: op = OP_ADD;
			P_MOVF: op = OP_MOVF;
			P_COMF: op = OP_COMF;
			P_INC: op = OP_INC;
			P_DECSK: op = OP_DEC_SKIP;
			P_RR: op = OP_ROT_RIGHT;
			P_RL: op = OP_ROT_LEFT;
			P_SWAP: op = OP_SWAP;
			P_INCSK: op = OP_INC_SKIP;
			P_BCLR: op = OP_BIT_CLR;
			P_BSET: op = OP_BIT_SET;
			P_TCLR: op = OP_TEST_CLR;
			P_TSET: op = OP_TEST_SET;
			P_RETL: op = OP_RET_LIT;
			P_CALL: op = OP_CALL;
			P_BRANCH: op = OP_BRANCH;
			P_MOVL: op = OP_MOVE_LIT;
			P_ORL: op = OP_OR_LIT;
			P_ANDL: op = OP_AND_LIT;
			P_XORL: op = OP_XOR_LIT;
			default: op = OP_ILLEGAL;
		endcase
		return op;
	endfunction
endpackage

/* tid_alu.sv */
// arithmetic and logic unit of the instruction decoder
`timescale 1ns/1ps
module tid_alu import tid_pkg::*; (
	input wire tid_op_t op,
	input wire logic [7:0] acc,
	input wire logic [7:0] fval,
	input wire logic [7:0] lit,
	input wire logic [2:0] bsel,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out,
	output logic dcarry_out,
	output logic zero_out
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] mask;

	always_comb begin
		sum = {1'b0, fval} + {1'b0, acc};
		nib = {1'b0, fval[3:0]} + {1'b0, acc[3:0]};
		mask = 8'h01 << bsel;
		result = fval;
		carry_out = carry_in;
		dcarry_out = 1'b0;
		case (op)
			OP_ADD: begin
				result = sum[7:0];
				carry_out = sum[8];
				dcarry_out = nib[4];
			end
			OP_SUB: begin
				// carry set means no borrow
				sum = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
				nib = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				result = sum[7:0];
				carry_out = sum[8];
				dcarry_out = nib[4];
			end
			OP_OR: result = acc | fval;
			OP_AND: result = acc & fval;
			OP_XOR: result = acc ^ fval;
			OP_COMF: result = ~fval;
			OP_INC, OP_INC_SKIP: result = fval + 8'h01;
			OP_DEC, OP_DEC_SKIP: result = fval - 8'h01;
			OP_ROT_LEFT: begin
				result = {fval[6:0], carry_in};
				carry_out = fval[7];
			end
			OP_ROT_RIGHT: begin
				result = {carry_in, fval[7:1]};
				carry_out = fval[0];
			end
			OP_SWAP: result = {fval[3:0], fval[7:4]};
			OP_BIT_CLR: result = fval & ~mask;
			OP_BIT_SET: result = fval | mask;
			OP_MOVWF: result = acc;
			OP_CLRW, OP_CLRF: result = ZERO_BYTE;
			OP_MOVE_LIT, OP_RET_LIT: result = lit;
			OP_OR_LIT: result = acc | lit;
			OP_AND_LIT: result = acc & lit;
			OP_XOR_LIT: result = acc ^ lit;
			default: result = fval;
		endcase
		zero_out = (result == ZERO_BYTE);
	end
endmodule

/* tid_core.sv */
// instruction decoder and executor of the 8-bit core
`timescale 1ns/1ps
// Operation
// - add/subtract, d selects destination, C DC Z
// - logic, move, inc/dec, clear update zero only
// - rotates through carry, only carry changes
// - decrement, skip next when zero, no flags
// - increment, skip next when zero, no flags
// - bit clear forces selected bit low
// - bit set forces selected bit high
// - bit test true discards next, runs nop
// - literal and into accumulator, updates zero
// - literal xor/or update zero, move not
// - call clears pc bit 8; jumps take two
// - return loads literal into accumulator, two cycles
// - standby, watchdog clear, option load words
// - direction load field 6 copies accumulator
// - port read-modify-write reads pin levels
// - timer write clears assigned prescaler
// - instruction cycle is four clocks
module tid_core import tid_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] instr,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] pins_in,
	input wire logic prescaler_assigned,
	input wire logic wake,
	output logic [8:0] pc,
	output logic cycle_strobe,
	output logic [4:0] file_raddr,
	output logic [4:0] file_waddr,
	output logic [7:0] file_wdata,
	output logic file_we,
	output logic [7:0] port_latch,
	output logic [7:0] port_dir,
	output logic [7:0] acc,
	output logic [7:0] option_value,
	output logic carry_flag,
	output logic digit_carry_flag,
	output logic zero_flag,
	output logic timeout_flag,
	output logic powerdown_flag,
	output logic standby,
	output logic prescaler_clear,
	output logic watchdog_clear
);
	logic [1:0] div_r, div_nxt;
	logic [8:0] pc_r, pc_nxt;
	logic [8:0] stk0_r, stk0_nxt, stk1_r, stk1_nxt;
	logic discard_r, discard_nxt;
	logic standby_r, standby_nxt;
	logic [7:0] acc_r, acc_nxt, option_r, option_nxt;
	logic [7:0] port_r, port_nxt, dir_r, dir_nxt;
	logic carry_r, carry_nxt, dcarry_r, dcarry_nxt, zero_r, zero_nxt;
	logic timeout_r, timeout_nxt, powerdown_r, powerdown_nxt;
	logic [4:0] waddr_r, waddr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic we_r, we_nxt, presc_r, presc_nxt, wdt_r, wdt_nxt;

	tid_op_t op;
	logic strobe, exec, dest_f, to_acc, to_file, upd_z, upd_c, skip;
	logic [4:0] reg_addr;
	logic [2:0] bsel;
	logic [7:0] lit, fval, alu_res;
	logic alu_c, alu_dc, alu_z;

	assign strobe = (div_r == DIV_LAST);
	assign exec = strobe && !discard_r && !standby_r;
	assign op = tid_decode(instr);
	assign reg_addr = instr[REG_MSB:REG_LSB];
	assign dest_f = instr[DEST_POS];
	assign bsel = instr[BIT_MSB:BIT_LSB];
	assign lit = instr[LIT_MSB:0];
	// port operand comes from the pins, not the latch
	assign fval = (reg_addr == PORT_ADDR) ? pins_in : file_rdata;

	tid_alu u_alu (
		.op(op),
		.acc(acc_r),
		.fval(fval),
		.lit(lit),
		.bsel(bsel),
		.carry_in(carry_r),
		.result(alu_res),
		.carry_out(alu_c),
		.dcarry_out(alu_dc),
		.zero_out(alu_z)
	);

	always_comb begin
		to_acc = 1'b0;
		to_file = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		skip = 1'b0;
		case (op)
			OP_ADD, OP_SUB: begin
				to_acc = !dest_f;
				to_file = dest_f;
				upd_z = 1'b1;
				upd_c = 1'b1;
			end
			OP_OR, OP_AND, OP_XOR, OP_MOVF, OP_COMF, OP_INC, OP_DEC: begin
				to_acc = !dest_f;
				to_file = dest_f;
				upd_z = 1'b1;
			end
			OP_CLRW: begin
				to_acc = 1'b1;
				upd_z = 1'b1;
			end
			OP_CLRF: begin
				to_file = 1'b1;
				upd_z = 1'b1;
			end
			OP_SWAP: begin
				to_acc = !dest_f;
				to_file = dest_f;
			end
			OP_MOVWF: to_file = 1'b1;
			OP_ROT_LEFT, OP_ROT_RIGHT: begin
				to_acc = !dest_f;
				to_file = dest_f;
			end
			OP_DEC_SKIP: begin
				to_acc = !dest_f;
				to_file = dest_f;
				skip = alu_z;
			end
			OP_INC_SKIP: begin
				to_acc = !dest_f;
				to_file = dest_f;
				skip = alu_z;
			end
			OP_BIT_CLR: to_file = 1'b1;
			OP_BIT_SET: to_file = 1'b1;
			OP_TEST_CLR: skip = !fval[bsel];
			OP_TEST_SET: skip = fval[bsel];
			OP_AND_LIT: begin
				to_acc = 1'b1;
				upd_z = 1'b1;
			end
			OP_OR_LIT, OP_XOR_LIT: begin
				to_acc = 1'b1;
				upd_z = 1'b1;
			end
			OP_MOVE_LIT, OP_RET_LIT: to_acc = 1'b1;
			default: to_acc = 1'b0;
		endcase
	end

	always_comb begin
		div_nxt = div_r + 2'h1;
		pc_nxt = pc_r;
		stk0_nxt = stk0_r;
		stk1_nxt = stk1_r;
		discard_nxt = discard_r;
		standby_nxt = standby_r;
		acc_nxt = acc_r;
		option_nxt = option_r;
		port_nxt = port_r;
		dir_nxt = dir_r;
		carry_nxt = carry_r;
		dcarry_nxt = dcarry_r;
		zero_nxt = zero_r;
		timeout_nxt = timeout_r;
		powerdown_nxt = powerdown_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		we_nxt = 1'b0;
		presc_nxt = 1'b0;
		wdt_nxt = 1'b0;
		if (standby_r && wake) begin
			standby_nxt = 1'b0;
		end
		if (strobe && discard_r && !standby_r) begin
			// second cycle of a jump or skip: nop, pc holds
			discard_nxt = 1'b0;
		end else if (exec) begin
			// all-zero word only advances pc and falls through every other action below
			pc_nxt = pc_r + PC_STEP;
			if (to_acc) begin
				acc_nxt = alu_res;
			end
			if (to_file) begin
				if (reg_addr == PORT_ADDR) begin
					port_nxt = alu_res;
				end else begin
					we_nxt = 1'b1;
					waddr_nxt = reg_addr;
					wdata_nxt = alu_res;
				end
				if (reg_addr == TIMER_ADDR && prescaler_assigned) begin
					presc_nxt = 1'b1;
				end
			end
			if (upd_z) begin
				zero_nxt = alu_z;
			end
			if (upd_c) begin
				dcarry_nxt = alu_dc;
			end
			if (upd_c || op == OP_ROT_LEFT || op == OP_ROT_RIGHT) begin
				carry_nxt = alu_c;
			end
			if (skip) begin
				pc_nxt = pc_r + PC_SKIP_STEP;
				discard_nxt = 1'b1;
			end
			case (op)
				OP_OPTION: option_nxt = acc_r;
				OP_SLEEP: begin
					timeout_nxt = 1'b1;
					powerdown_nxt = 1'b0;
					standby_nxt = 1'b1;
				end
				OP_WDT_CLR: begin
					timeout_nxt = 1'b1;
					powerdown_nxt = 1'b1;
					wdt_nxt = 1'b1;
				end
				OP_DIR_LOAD: begin
					if (instr[DIR_SEL_MSB:0] == DIR_PORT_SEL) begin
						dir_nxt = acc_r;
					end
				end
				OP_CALL: begin
					stk1_nxt = stk0_r;
					stk0_nxt = pc_r + PC_STEP;
					pc_nxt = {1'b0, lit};
					discard_nxt = 1'b1;
				end
				OP_RET_LIT: begin
					pc_nxt = stk0_r;
					stk0_nxt = stk1_r;
					discard_nxt = 1'b1;
				end
				OP_BRANCH: begin
					pc_nxt = instr[TGT_MSB:0];
					discard_nxt = 1'b1;
				end
				default: discard_nxt = discard_nxt;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			div_r <= 2'h0;
			pc_r <= PC_RESET;
			stk0_r <= PC_RESET;
			stk1_r <= PC_RESET;
			discard_r <= 1'b0;
			standby_r <= 1'b0;
			acc_r <= ZERO_BYTE;
			option_r <= OPTION_RESET;
			port_r <= ZERO_BYTE;
			dir_r <= DIR_RESET;
			carry_r <= 1'b0;
			dcarry_r <= 1'b0;
			zero_r <= 1'b0;
			timeout_r <= 1'b1;
			powerdown_r <= 1'b1;
			waddr_r <= 5'h00;
			wdata_r <= ZERO_BYTE;
			we_r <= 1'b0;
			presc_r <= 1'b0;
			wdt_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			pc_r <= pc_nxt;
			stk0_r <= stk0_nxt;
			stk1_r <= stk1_nxt;
			discard_r <= discard_nxt;
			standby_r <= standby_nxt;
			acc_r <= acc_nxt;
			option_r <= option_nxt;
			port_r <= port_nxt;
			dir_r <= dir_nxt;
			carry_r <= carry_nxt;
			dcarry_r <= dcarry_nxt;
			zero_r <= zero_nxt;
			timeout_r <= timeout_nxt;
			powerdown_r <= powerdown_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			we_r <= we_nxt;
			presc_r <= presc_nxt;
			wdt_r <= wdt_nxt;
		end
	end

	assign pc = pc_r;
	assign cycle_strobe = strobe;
	assign file_raddr = reg_addr;
	assign file_waddr = waddr_r;
	assign file_wdata = wdata_r;
	assign file_we = we_r;
	assign port_latch = port_r;
	assign port_dir = dir_r;
	assign acc = acc_r;
	assign option_value = option_r;
	assign carry_flag = carry_r;
	assign digit_carry_flag = dcarry_r;
	assign zero_flag = zero_r;
	assign timeout_flag = timeout_r;
	assign powerdown_flag = powerdown_r;
	assign standby = standby_r;
	assign prescaler_clear = presc_r;
	assign watchdog_clear = wdt_r;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence seq_discard_cycle;
		discard_r [*4] ##1 !discard_r;
	endsequence

	chk_add_dest: assert property (exec && op == OP_ADD && !dest_f |=>
		acc_r == $past(alu_res) && carry_r == $past(alu_c) && !we_r)
		else $error("add result not in accumulator");
	chk_logic_flags: assert property (exec && op == OP_XOR |=>
		carry_r == $past(carry_r) && zero_r == $past(alu_z))
		else $error("logic op flag update wrong");
	chk_rotate_flags: assert property (exec && op == OP_ROT_LEFT |=>
		zero_r == $past(zero_r) && carry_r == $past(fval[7]))
		else $error("rotate flags wrong");
	chk_skip_dec: assert property (exec && op == OP_DEC_SKIP && alu_z
		|=> seq_discard_cycle)
		else $error("decrement skip not two cycles");
	chk_bit_set: assert property (exec && op == OP_BIT_SET
		&& reg_addr != PORT_ADDR |=> we_r && wdata_r[$past(bsel)])
		else $error("bit set did not write one");
	chk_test_skip: assert property (exec && op == OP_TEST_SET
		&& fval[bsel] |=> pc_r == $past(pc_r) + PC_SKIP_STEP
		##0 seq_discard_cycle)
		else $error("bit test skip wrong");
	chk_literal_and: assert property (exec && op == OP_AND_LIT |=>
		acc_r == ($past(acc_r) & $past(lit)) && zero_r == (acc_r == 0))
		else $error("literal and wrong");
	chk_call_bit: assert property (exec && op == OP_CALL |=>
		!pc_r[8] && stk0_r == $past(pc_r) + PC_STEP && discard_r)
		else $error("call target or push wrong");
	chk_dir_load: assert property (exec && op == OP_DIR_LOAD
		&& instr[DIR_SEL_MSB:0] == DIR_PORT_SEL |=> dir_r == $past(acc_r))
		else $error("direction latch not loaded");
	chk_presc_clear: assert property (exec && to_file
		&& reg_addr == TIMER_ADDR && prescaler_assigned |=> presc_r ##1 !presc_r)
		else $error("prescaler clear missing");
	chk_cycle_len: assert property (strobe |=> !strobe [*3] ##1 strobe)
		else $error("instruction cycle not four clocks");
	chk_nop_quiet: assert property (exec && op == OP_NOP |=>
		$stable(acc_r) && $stable(zero_r) && $stable(carry_r) && !we_r)
		else $error("nop changed state");
endmodule

/* tid_prog_mem.sv */
// program memory and file register model facing the decoder
`timescale 1ns/1ps
module tid_prog_mem (
	input wire logic clk,
	input wire logic [8:0] pc,
	input wire logic [4:0] file_raddr,
	input wire logic [4:0] file_waddr,
	input wire logic [7:0] file_wdata,
	input wire logic file_we,
	output logic [11:0] instr,
	output logic [7:0] file_rdata
);
	logic [11:0] rom [0:511];
	logic [7:0] regs [0:31];

	// unloaded words read as the all-zero word
	initial begin
		for (int i = 0; i < 512; i++) begin
			rom[i] = 12'h000;
		end
		for (int i = 0; i < 32; i++) begin
			regs[i] = 8'h00;
		end
	end

	assign instr = rom[pc];
	assign file_rdata = regs[file_raddr];

	always @(posedge clk) begin
		if (file_we) begin
			regs[file_waddr] <= file_wdata;
		end
	end
endmodule

/* twelve_bit_instruction_decoder_tb.sv */
// self-checking bench of the instruction decoder
`timescale 1ns/1ps
module twelve_bit_instruction_decoder_tb;
	logic clk, reset, prescaler_assigned, wake, gap_chk;
	logic [7:0] pins_in, file_rdata, file_wdata, port_latch, port_dir;
	logic [7:0] acc, option_value;
	logic [11:0] instr;
	logic [8:0] pc;
	logic [4:0] file_raddr, file_waddr;
	logic cycle_strobe, file_we, carry_flag, digit_carry_flag, zero_flag;
	logic timeout_flag, powerdown_flag, standby;
	logic prescaler_clear, watchdog_clear;
	int fails, cmp_count, k;
	logic [11:0] prog [0:34];
	logic [11:0] prog2 [0:10];

	tid_core dut_u (.clk(clk), .reset(reset), .instr(instr),
		.file_rdata(file_rdata), .pins_in(pins_in),
		.prescaler_assigned(prescaler_assigned), .wake(wake), .pc(pc),
		.cycle_strobe(cycle_strobe), .file_raddr(file_raddr),
		.file_waddr(file_waddr), .file_wdata(file_wdata),
		.file_we(file_we), .port_latch(port_latch), .port_dir(port_dir),
		.acc(acc), .option_value(option_value), .carry_flag(carry_flag),
		.digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
		.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
		.standby(standby), .prescaler_clear(prescaler_clear),
		.watchdog_clear(watchdog_clear));

	tid_prog_mem mem_u (.clk(clk), .pc(pc), .file_raddr(file_raddr),
		.file_waddr(file_waddr), .file_wdata(file_wdata),
		.file_we(file_we), .instr(instr), .file_rdata(file_rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task tally_and_finish;
		$display("mismatches %0d, comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#10000;
		fails++;
		tally_and_finish();
	end

	task fail_msg(input string what);
		fails++;
		$display("FAIL %0t %s", $time, what);
	endtask

	// waits for the taking edge, then lets its results land
	task st;
		int n;
		n = 0;
		while (cycle_strobe !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (gap_chk) begin
			cmp_count++;
			if (n != 3) fail_msg("instruction cycle length");
		end
		@(posedge clk);
		#1;
	endtask

	task cs(input logic [7:0] a, input logic [2:0] f, input logic [8:0] p);
		cmp_count++;
		if (acc !== a || pc !== p ||
			{carry_flag, digit_carry_flag, zero_flag} !== f) begin
			fail_msg($sformatf("state acc %h pc %h", acc, pc));
		end
	endtask

	task ex(input logic [7:0] a, input logic [2:0] f, input logic [8:0] p);
		st();
		cs(a, f, p);
	endtask

	task cw(input logic [4:0] ad, input logic [7:0] d);
		cmp_count++;
		if (file_we !== 1'b1 || file_waddr !== ad || file_wdata !== d) begin
			fail_msg($sformatf("file write %h %h", file_waddr, file_wdata));
		end
	endtask

	task cb(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) fail_msg($sformatf("byte %h exp %h", got, exp));
	endtask

	task c1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) fail_msg($sformatf("bit %b exp %b", got, exp));
	endtask

	initial begin
		reset = 1'b1;
		wake = 1'b0;
		pins_in = 8'h3c;
		prescaler_assigned = 1'b1;
		gap_chk = 1'b0;
		prog = '{12'hC0A, 12'h1C5, 12'hC35, 12'h0A5, 12'hE0F, 12'hF05,
			12'hD80, 12'h345, 12'h305, 12'h10A, 12'h18A, 12'h14A, 12'h2EB,
			12'hC55, 12'h3EC, 12'hC66, 12'h4E5, 12'h525, 12'h645, 12'hC77,
			12'h705, 12'hC88, 12'h745, 12'hC5A, 12'h006, 12'h005, 12'h002,
			12'h003, 12'h004, 12'h000, 12'h226, 12'h021, 12'h940, 12'hBF0,
			12'hC99};
		repeat (5) @(posedge clk);
		for (int i = 0; i < 35; i++) begin
			mem_u.rom[i] = prog[i];
		end
		mem_u.rom[9'h040] = 12'h8A7;
		mem_u.rom[9'h1F0] = 12'h950;
		// byte ops not reached by the first program, then a timer write
		prog2 = '{12'h040, 12'h38A, 12'h245, 12'h06B, 12'h2AC, 12'h0CC,
			12'hC10, 12'h08A, 12'h1EC, 12'h2CA, 12'h021};
		for (int i = 0; i < 11; i++) begin
			mem_u.rom[9'h051 + i] = prog2[i];
		end
		mem_u.regs[5] = 8'hf6;
		mem_u.regs[10] = 8'h0f;
		mem_u.regs[11] = 8'h01;
		mem_u.regs[12] = 8'hff;
		reset <= 1'b0;
		#1;
		cs(8'h00, 3'h0, 9'h000);
		cb(port_dir, 8'hff);
		cb(option_value, 8'hff);
		c1(timeout_flag & powerdown_flag, 1'b1);
		ex(8'h0a, 3'h0, 9'h001);
		gap_chk = 1'b1;
		ex(8'h00, 3'h7, 9'h002);
		ex(8'h35, 3'h7, 9'h003);
		ex(8'h35, 3'h6, 9'h004);
		cw(5'h05, 8'hc1);
		ex(8'h05, 3'h6, 9'h005);
		ex(8'h00, 3'h7, 9'h006);
		ex(8'h80, 3'h6, 9'h007);
		ex(8'h83, 3'h6, 9'h008);
		ex(8'he0, 3'h6, 9'h009);
		ex(8'hef, 3'h6, 9'h00a);
		ex(8'he0, 3'h6, 9'h00b);
		ex(8'h00, 3'h7, 9'h00c);
		ex(8'h00, 3'h7, 9'h00e);
		cw(5'h0b, 8'h00);
		ex(8'h00, 3'h7, 9'h00e);
		ex(8'h00, 3'h7, 9'h010);
		cw(5'h0c, 8'h00);
		ex(8'h00, 3'h7, 9'h010);
		ex(8'h00, 3'h7, 9'h011);
		cw(5'h05, 8'h41);
		ex(8'h00, 3'h7, 9'h012);
		cw(5'h05, 8'h43);
		ex(8'h00, 3'h7, 9'h014);
		ex(8'h00, 3'h7, 9'h014);
		ex(8'h00, 3'h7, 9'h016);
		ex(8'h00, 3'h7, 9'h016);
		ex(8'h00, 3'h7, 9'h017);
		ex(8'h5a, 3'h7, 9'h018);
		ex(8'h5a, 3'h7, 9'h019);
		cb(port_dir, 8'h5a);
		ex(8'h5a, 3'h7, 9'h01a);
		cb(port_dir, 8'h5a);
		ex(8'h5a, 3'h7, 9'h01b);
		cb(option_value, 8'h5a);
		ex(8'h5a, 3'h7, 9'h01c);
		c1(standby, 1'b1);
		c1(powerdown_flag, 1'b0);
		c1(timeout_flag, 1'b1);
		gap_chk = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		cs(8'h5a, 3'h7, 9'h01c);
		@(posedge clk) wake <= 1'b1;
		k = 0;
		while (standby !== 1'b0 && k < 16) begin
			@(posedge clk);
			#1;
			k++;
		end
		@(posedge clk) wake <= 1'b0;
		#1;
		if (k >= 16) fail_msg("standby not left");
		ex(8'h5a, 3'h7, 9'h01d);
		c1(watchdog_clear, 1'b1);
		c1(powerdown_flag, 1'b1);
		gap_chk = 1'b1;
		ex(8'h5a, 3'h7, 9'h01e);
		c1(file_we, 1'b0);
		ex(8'h5a, 3'h6, 9'h01f);
		cb(port_latch, 8'h3c);
		ex(8'h5a, 3'h6, 9'h020);
		c1(prescaler_clear, 1'b1);
		cw(5'h01, 8'h5a);
		ex(8'h5a, 3'h6, 9'h040);
		ex(8'h5a, 3'h6, 9'h040);
		ex(8'ha7, 3'h6, 9'h021);
		ex(8'ha7, 3'h6, 9'h021);
		ex(8'ha7, 3'h6, 9'h1f0);
		ex(8'ha7, 3'h6, 9'h1f0);
		ex(8'ha7, 3'h6, 9'h050);
		ex(8'ha7, 3'h6, 9'h050);
		ex(8'ha7, 3'h6, 9'h051);
		ex(8'h00, 3'h7, 9'h052);
		ex(8'hf0, 3'h7, 9'h053);
		ex(8'hbc, 3'h6, 9'h054);
		ex(8'hbc, 3'h7, 9'h055);
		cw(5'h0b, 8'h00);
		ex(8'hbc, 3'h6, 9'h056);
		cw(5'h0c, 8'h01);
		ex(8'h00, 3'h7, 9'h057);
		ex(8'h10, 3'h7, 9'h058);
		ex(8'hff, 3'h2, 9'h059);
		ex(8'hff, 3'h7, 9'h05a);
		cw(5'h0c, 8'h00);
		ex(8'h0e, 3'h7, 9'h05b);
		// timer write with the prescaler elsewhere must not clear it
		gap_chk = 1'b0;
		@(posedge clk) prescaler_assigned <= 1'b0;
		ex(8'h0e, 3'h7, 9'h05c);
		cw(5'h01, 8'h0e);
		c1(prescaler_clear, 1'b0);
		tally_and_finish();
	end
endmodule
